// [pkg/cspc_pkg.sv]
package cspc_pkg;
  localparam logic [8:0] PLL_CONTROL_ADDR = 9'h1e4;
  localparam logic [8:0] OUT_DRIVE_ADDR = 9'h1c0;
  localparam logic [8:0] SLOW_CTRL_ADDR = 9'h1e6;
  localparam logic [8:0] CLK_STATUS_ADDR = 9'h1e7;
  localparam logic [7:0] PLL_CONTROL_RESET = 8'h1b;
  localparam logic [7:0] PLL_CONTROL_MASK = 8'h1f;
  localparam logic [7:0] OUT_DRIVE_RESET = 8'h04;
  localparam logic [7:0] PLL_RATIO_BASE = 8'h70;
  localparam int PLL_RATIO_LSB = 0;
  localparam int PLL_SIXTEEN_BIT = 3;
  localparam int PLL_FORCE_BIT = 4;
  localparam int SLOW_DRV_LSB = 0;
  localparam int AUDIO_DRV_LSB = 2;
  localparam int SLOW_DISABLE_BIT = 0;
  localparam int STAT_RC_BIT = 0;
  localparam int STAT_XTAL_BIT = 1;
  localparam int STAT_TEST_BIT = 2;
  localparam logic [1:0] DRV_MEDIUM = 2'h0;
  localparam logic [1:0] DRV_FAST = 2'h1;
  localparam logic [1:0] DRV_HIZ = 2'h2;
  localparam logic [1:0] DRV_SLOW = 2'h3;
  localparam int SYN_XTAL = 0;
  localparam int SYN_RC = 1;
  localparam int SYN_AUDIO = 2;
  localparam int SYN_START = 3;
  localparam int SYN_RAIL = 4;
  localparam int SYN_REQ = 5;
  localparam int SYN_TEST = 6;
  localparam int SYN_BKUP = 7;
  localparam logic [7:0] SYNC_RESET = 8'h80;
  localparam logic [3:0] MON_WINDOW_RC_EDGES = 4'h8;
  localparam logic [3:0] MON_MIN_XTAL_EDGES = 4'h4;
endpackage : cspc_pkg

// [pkg/cspc_clk_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface cspc_clk_if;
  logic xtal_lvl;
  logic rc_lvl;
  logic xtal_rise;
  logic rc_rise;
  logic xtal_running;
  logic rc_sel;
  logic mux_lvl;
  modport core (output xtal_lvl, rc_lvl, xtal_rise, rc_rise, input xtal_running, rc_sel, mux_lvl);
  modport monitor (input xtal_rise, rc_rise, output xtal_running);
  modport mux (input xtal_lvl, rc_lvl, xtal_running, output rc_sel, mux_lvl);
endinterface : cspc_clk_if
`default_nettype wire

// [logic/cspc_xtal_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module cspc_xtal_monitor
  import cspc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Edge events
  cspc_clk_if.monitor cif
);
  logic [3:0] rc_cnt_ff;
  logic [3:0] xtal_cnt_ff;
  logic running_ff;

  assign cif.xtal_running = running_ff;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rc_cnt_ff <= 4'h0;
      xtal_cnt_ff <= 4'h0;
      running_ff <= 1'b0;
    end
    else if (cif.xtal_rise && xtal_cnt_ff == MON_MIN_XTAL_EDGES - 4'h1)
    begin
      rc_cnt_ff <= 4'h0;
      xtal_cnt_ff <= 4'h0;
      running_ff <= 1'b1;
    end
    else if (cif.rc_rise && rc_cnt_ff == MON_WINDOW_RC_EDGES - 4'h1)
    begin
      rc_cnt_ff <= 4'h0;
      xtal_cnt_ff <= 4'h0;
      running_ff <= 1'b0;
    end
    else
    begin
      rc_cnt_ff <= rc_cnt_ff + {3'h0, cif.rc_rise};
      xtal_cnt_ff <= xtal_cnt_ff + {3'h0, cif.xtal_rise};
    end
  end

  property p_stop_at_window_end;
    @(posedge clk) disable iff (rst)
    $fell(running_ff) |-> $past(cif.rc_rise) && $past(rc_cnt_ff) == MON_WINDOW_RC_EDGES - 4'h1;
  endproperty
  a_stop_at_window_end : assert property (p_stop_at_window_end)
    else $error("crystal declared stopped outside window end");

  property p_run_on_enough_edges;
    @(posedge clk) disable iff (rst)
    $rose(running_ff) |-> $past(cif.xtal_rise) && $past(xtal_cnt_ff) == MON_MIN_XTAL_EDGES - 4'h1;
  endproperty
  a_run_on_enough_edges : assert property (p_run_on_enough_edges)
    else $error("crystal declared running without enough edges");
endmodule : cspc_xtal_monitor
`default_nettype wire

// [logic/cspc_glitch_mux.sv]
`timescale 1ns/1ps
`default_nettype none
module cspc_glitch_mux
  import cspc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Source levels and selection
  cspc_clk_if.mux cif
);
  logic rc_sel_ff;
  logic nxt_rc_sel;

  assign cif.rc_sel = rc_sel_ff;
  assign cif.mux_lvl = rc_sel_ff ? cif.rc_lvl : cif.xtal_lvl;

  assign nxt_rc_sel = ~cif.xtal_running;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rc_sel_ff <= 1'b1;
    end
    else if (!cif.xtal_lvl && !cif.rc_lvl)
    begin
      rc_sel_ff <= nxt_rc_sel;
    end
  end

  property p_switch_when_low;
    @(posedge clk) disable iff (rst)
    $changed(rc_sel_ff) |-> $past(!cif.xtal_lvl && !cif.rc_lvl);
  endproperty
  a_switch_when_low : assert property (p_switch_when_low)
    else $error("source switched outside common low phase");

  property p_keep_crystal;
    @(posedge clk) disable iff (rst)
    cif.xtal_running && !rc_sel_ff |=> !rc_sel_ff;
  endproperty
  a_keep_crystal : assert property (p_keep_crystal)
    else $error("left active crystal source");

  property p_fallback_rc;
    @(posedge clk) disable iff (rst)
    !cif.xtal_running && !cif.xtal_lvl && !cif.rc_lvl |=> rc_sel_ff;
  endproperty
  a_fallback_rc : assert property (p_fallback_rc)
    else $error("no fallback to RC source");
endmodule : cspc_glitch_mux
`default_nettype wire

// [logic/cspc_top.sv]
`timescale 1ns/1ps
`default_nettype none
module cspc_top
  import cspc_pkg::*;
(
  // Clock and resets
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic BACKUP_DOMAIN_RESET_N,
  // Register port
  input wire logic [8:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // Clock pins and system inputs
  input wire logic XTAL_CLK_IN,
  input wire logic RC_CLK_IN,
  input wire logic AUDIO_XTAL_IN,
  input wire logic STARTUP_DRV_EN,
  input wire logic COMPANION_RAIL_EN,
  input wire logic BLOCK_CLK_REQ,
  input wire logic FACTORY_TEST_SELECT,
  // Slow clock output
  output logic SLOW_CLOCK_OUT,
  output logic SLOW_CLOCK_OE,
  output logic [1:0] SLOW_CLOCK_DRIVE_STRENGTH,
  // Audio clock output
  output logic AUDIO_CLOCK_OUT,
  output logic AUDIO_CLOCK_OE,
  output logic [1:0] AUDIO_CLOCK_DRIVE_STRENGTH,
  // PLL control
  output logic [7:0] PLL_RATIO,
  output logic PLL_RUN,
  output logic SIXTEEN_MHZ_CLOCK_ENABLE,
  // Status and protection
  output logic RC_SOURCE_SELECTED,
  output logic FUSE_PROG_BLOCK
);
  logic [7:0] pin_in;
  logic [7:0] sync1_ff;
  logic [7:0] sync2_ff;
  logic xtal_d_ff;
  logic rc_d_ff;
  logic [7:0] pll_control_ff;
  logic [7:0] out_drive_ff;
  logic slow_clock_output_disable_ff;
  logic [7:0] nxt_rdata;
  logic [7:0] status;
  logic pll_wr;
  logic drive_wr;
  logic slow_wr;
  logic backup_rst;
  logic [1:0] slow_drv;
  logic [1:0] audio_drv;
  logic [2:0] pll_ratio_select;
  logic sixteen_en;
  logic pll_force_on;

  cspc_clk_if cif ();

  assign pin_in = {BACKUP_DOMAIN_RESET_N, FACTORY_TEST_SELECT, BLOCK_CLK_REQ, COMPANION_RAIL_EN,
                   STARTUP_DRV_EN, AUDIO_XTAL_IN, RC_CLK_IN, XTAL_CLK_IN};

  // Two-stage synchronisers; backup pin ignores system reset
  for (genvar i = 0; i < 8; i++)
  begin : g_sync
    always_ff @(posedge CORE_CLK)
    begin
      if (SYS_RST && i != SYN_BKUP)
      begin
        sync1_ff[i] <= SYNC_RESET[i];
        sync2_ff[i] <= SYNC_RESET[i];
      end
      else
      begin
        sync1_ff[i] <= pin_in[i];
        sync2_ff[i] <= sync1_ff[i];
      end
    end
  end

  // Edge detect on synchronised clocks
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      xtal_d_ff <= 1'b0;
      rc_d_ff <= 1'b0;
    end
    else
    begin
      xtal_d_ff <= sync2_ff[SYN_XTAL];
      rc_d_ff <= sync2_ff[SYN_RC];
    end
  end

  assign cif.xtal_lvl = sync2_ff[SYN_XTAL];
  assign cif.rc_lvl = sync2_ff[SYN_RC];
  assign cif.xtal_rise = sync2_ff[SYN_XTAL] & ~xtal_d_ff;
  assign cif.rc_rise = sync2_ff[SYN_RC] & ~rc_d_ff;

  cspc_xtal_monitor u_monitor (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .cif(cif.monitor)
  );

  cspc_glitch_mux u_mux (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .cif(cif.mux)
  );

  // Register decode
  assign pll_wr = REG_WR && REG_ADDR == PLL_CONTROL_ADDR;
  assign drive_wr = REG_WR && REG_ADDR == OUT_DRIVE_ADDR;
  assign slow_wr = REG_WR && REG_ADDR == SLOW_CTRL_ADDR;
  assign backup_rst = ~sync2_ff[SYN_BKUP];

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      pll_control_ff <= PLL_CONTROL_RESET;
    end
    else if (pll_wr)
    begin
      pll_control_ff <= REG_WDATA & PLL_CONTROL_MASK;
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      out_drive_ff <= OUT_DRIVE_RESET;
    end
    else if (drive_wr)
    begin
      out_drive_ff <= REG_WDATA;
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (backup_rst)
    begin
      slow_clock_output_disable_ff <= 1'b0;
    end
    else if (slow_wr)
    begin
      slow_clock_output_disable_ff <= REG_WDATA[SLOW_DISABLE_BIT];
    end
  end

  assign pll_ratio_select = pll_control_ff[PLL_RATIO_LSB +: 3];
  assign sixteen_en = pll_control_ff[PLL_SIXTEEN_BIT];
  assign pll_force_on = pll_control_ff[PLL_FORCE_BIT];
  assign slow_drv = out_drive_ff[SLOW_DRV_LSB +: 2];
  assign audio_drv = out_drive_ff[AUDIO_DRV_LSB +: 2];

  always_comb
  begin
    status = 8'h00;
    status[STAT_RC_BIT] = cif.rc_sel;
    status[STAT_XTAL_BIT] = cif.xtal_running;
    status[STAT_TEST_BIT] = sync2_ff[SYN_TEST];
  end

  // Read multiplexer
  always_comb
  begin
    case (REG_ADDR)
      PLL_CONTROL_ADDR: nxt_rdata = pll_control_ff;
      OUT_DRIVE_ADDR: nxt_rdata = out_drive_ff;
      SLOW_CTRL_ADDR: nxt_rdata = {7'h00, slow_clock_output_disable_ff};
      CLK_STATUS_ADDR: nxt_rdata = status;
      default: nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      REG_RDATA <= 8'h00;
    end
    else
    begin
      REG_RDATA <= REG_RD ? nxt_rdata : 8'h00;
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      PLL_RATIO <= 8'h00;
    end
    else
    begin
      PLL_RATIO <= PLL_RATIO_BASE + {3'h0, pll_ratio_select, 2'h0};
    end
  end

  // PLL run and 16 MHz enable
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      PLL_RUN <= 1'b0;
      SIXTEEN_MHZ_CLOCK_ENABLE <= 1'b0;
    end
    else
    begin
      PLL_RUN <= pll_force_on | sixteen_en | sync2_ff[SYN_REQ];
      SIXTEEN_MHZ_CLOCK_ENABLE <= sixteen_en;
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      SLOW_CLOCK_OUT <= 1'b0;
      SLOW_CLOCK_OE <= 1'b0;
      SLOW_CLOCK_DRIVE_STRENGTH <= DRV_MEDIUM;
    end
    else
    begin
      SLOW_CLOCK_OUT <= cif.mux_lvl & sync2_ff[SYN_START] & ~slow_clock_output_disable_ff;
      SLOW_CLOCK_OE <= sync2_ff[SYN_START] & ~slow_clock_output_disable_ff & (slow_drv != DRV_HIZ);
      SLOW_CLOCK_DRIVE_STRENGTH <= slow_drv;
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      AUDIO_CLOCK_OUT <= 1'b0;
      AUDIO_CLOCK_OE <= 1'b0;
      AUDIO_CLOCK_DRIVE_STRENGTH <= DRV_MEDIUM;
    end
    else
    begin
      AUDIO_CLOCK_OUT <= sync2_ff[SYN_AUDIO] & sync2_ff[SYN_RAIL];
      AUDIO_CLOCK_OE <= sync2_ff[SYN_RAIL] & (audio_drv != DRV_HIZ);
      AUDIO_CLOCK_DRIVE_STRENGTH <= audio_drv;
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      RC_SOURCE_SELECTED <= 1'b1;
      FUSE_PROG_BLOCK <= 1'b1;
    end
    else
    begin
      RC_SOURCE_SELECTED <= cif.rc_sel;
      FUSE_PROG_BLOCK <= 1'b1;
    end
  end

  property p_pll_write;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    pll_wr ##1 REG_RD && REG_ADDR == PLL_CONTROL_ADDR && !REG_WR |=> REG_RDATA == ($past(REG_WDATA, 2) & 8'h1f);
  endproperty
  a_pll_write : assert property (p_pll_write)
    else $error("control register readback wrong");

  property p_ratio;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    1'b1 |=> PLL_RATIO == PLL_RATIO_BASE + {3'h0, $past(pll_ratio_select), 2'h0};
  endproperty
  a_ratio : assert property (p_ratio)
    else $error("divide ratio mismatch");

  property p_sixteen;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    sixteen_en |=> SIXTEEN_MHZ_CLOCK_ENABLE && PLL_RUN;
  endproperty
  a_sixteen : assert property (p_sixteen)
    else $error("16 MHz enable without PLL run");

  property p_pll_idle;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    !pll_force_on && !sixteen_en && !sync2_ff[SYN_REQ] |=> !PLL_RUN && !SIXTEEN_MHZ_CLOCK_ENABLE;
  endproperty
  a_pll_idle : assert property (p_pll_idle)
    else $error("PLL running with no request");

  property p_status;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    REG_RD && REG_ADDR == CLK_STATUS_ADDR |=> REG_RDATA[STAT_RC_BIT] == RC_SOURCE_SELECTED;
  endproperty
  a_status : assert property (p_status)
    else $error("status bit disagrees with source pin");

  property p_slow_enable;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    sync2_ff[SYN_START] && !slow_clock_output_disable_ff && slow_drv != DRV_HIZ |=> SLOW_CLOCK_OE;
  endproperty
  a_slow_enable : assert property (p_slow_enable)
    else $error("slow clock driver not enabled");

  property p_backup_default;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    backup_rst |=> !slow_clock_output_disable_ff;
  endproperty
  a_backup_default : assert property (p_backup_default)
    else $error("driver disable bit not cleared by backup reset");

  property p_rail_gate;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    !sync2_ff[SYN_RAIL] |=> !AUDIO_CLOCK_OE && !AUDIO_CLOCK_OUT;
  endproperty
  a_rail_gate : assert property (p_rail_gate)
    else $error("audio clock driven without rail");

  property p_drive_fields;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    drive_wr |=> ##1 SLOW_CLOCK_DRIVE_STRENGTH == $past(REG_WDATA[1:0], 2) &&
      AUDIO_CLOCK_DRIVE_STRENGTH == $past(REG_WDATA[3:2], 2);
  endproperty
  a_drive_fields : assert property (p_drive_fields)
    else $error("drive strength does not follow field");

  property p_hiz;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    slow_drv == DRV_HIZ |=> !SLOW_CLOCK_OE;
  endproperty
  a_hiz : assert property (p_hiz)
    else $error("Hi-Z code still drives");

  property p_fuse;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    1'b1 |=> FUSE_PROG_BLOCK;
  endproperty
  a_fuse : assert property (p_fuse)
    else $error("fuse programming unblocked");
endmodule : cspc_top
`default_nettype wire

// [dv/cspc_clk_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module cspc_clk_partner (
  // Bench control
  input wire logic xtal_on,
  // Clock sources
  output logic xtal_clk,
  output logic rc_clk,
  output logic audio_clk,
  // Board strap
  output logic test_sel
);
  assign test_sel = 1'b0;
  initial
  begin
    xtal_clk = 1'b0;
    rc_clk = 1'b0;
    audio_clk = 1'b0;
  end
  // Backup oscillator always runs
  always #100 rc_clk = ~rc_clk;
  always #20 audio_clk = ~audio_clk;
  // Stopped crystal rests low
  always
  begin
    wait (xtal_on === 1'b1);
    #75;
    xtal_clk = xtal_on & ~xtal_clk;
  end
endmodule : cspc_clk_partner
`default_nettype wire

// [dv/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench
  import cspc_pkg::*;
;
  logic clk = 1'b0;
  logic rst, bk_n, wr, rd, st_en, rail, req, xon, watch;
  logic xclk, rcclk, aclk, tsel, s_out, s_oe, a_out, a_oe, run, m16, rcsel, fuse;
  logic [8:0] addr;
  logic [7:0] wdat, rdat, ratio, d;
  logic [1:0] s_drv, a_drv, s, a;
  int errors = 0;
  int comparisons = 0;
  int hi_cnt = 0;
  logic [31:0] rows [8] = '{32'he000_7000, 32'h0101_7400, 32'h0a0a_7803, 32'h1313_7c02,
    32'h1c1c_8003, 32'hf515_8402, 32'h0606_8800, 32'h0f0f_8c03};

  always #2.5 clk = ~clk;

  cspc_clk_partner cspc_clk_partner_i (.xtal_on(xon), .xtal_clk(xclk), .rc_clk(rcclk),
    .audio_clk(aclk), .test_sel(tsel));

  cspc_top cspc_top_i (.CORE_CLK(clk), .SYS_RST(rst), .BACKUP_DOMAIN_RESET_N(bk_n),
    .REG_ADDR(addr), .REG_WDATA(wdat), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdat),
    .XTAL_CLK_IN(xclk), .RC_CLK_IN(rcclk), .AUDIO_XTAL_IN(aclk), .STARTUP_DRV_EN(st_en),
    .COMPANION_RAIL_EN(rail), .BLOCK_CLK_REQ(req), .FACTORY_TEST_SELECT(tsel),
    .SLOW_CLOCK_OUT(s_out), .SLOW_CLOCK_OE(s_oe), .SLOW_CLOCK_DRIVE_STRENGTH(s_drv),
    .AUDIO_CLOCK_OUT(a_out), .AUDIO_CLOCK_OE(a_oe), .AUDIO_CLOCK_DRIVE_STRENGTH(a_drv),
    .PLL_RATIO(ratio), .PLL_RUN(run), .SIXTEEN_MHZ_CLOCK_ENABLE(m16),
    .RC_SOURCE_SELECTED(rcsel), .FUSE_PROG_BLOCK(fuse));

  task automatic wrap_up();
    if (errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  task automatic reg_write(input logic [8:0] ad, input logic [7:0] dt);
    @(negedge clk);
    addr = ad;
    wdat = dt;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [8:0] ad, output logic [7:0] dt);
    @(negedge clk);
    addr = ad;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    dt = rdat;
  endtask : reg_read

  task automatic write_read(input logic [8:0] ad, input logic [7:0] dt, output logic [7:0] rb);
    @(negedge clk);
    addr = ad;
    wdat = dt;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    rb = rdat;
  endtask : write_read

  task automatic wait_sel(input logic exp);
    int n;
    n = 0;
    while (rcsel !== exp && n < 4000)
    begin
      @(negedge clk);
      n++;
    end
    check({7'h00, rcsel}, {7'h00, exp});
  endtask : wait_sel

  // Runt pulses on the time base show a glitchy switch
  always @(negedge clk)
  begin
    if (s_out === 1'b1)
      hi_cnt <= hi_cnt + 1;
    else
    begin
      if (watch === 1'b1 && hi_cnt > 0)
        check({7'h00, hi_cnt < 10}, 8'h00);
      hi_cnt <= 0;
    end
  end

  initial
  begin
    #50000;
    errors++;
    wrap_up();
  end

  initial
  begin
    rst = 1'b1;
    bk_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 9'h000;
    wdat = 8'h00;
    st_en = 1'b1;
    rail = 1'b1;
    req = 1'b0;
    xon = 1'b0;
    watch = 1'b0;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    bk_n = 1'b1;
    tick(4);
    reg_read(PLL_CONTROL_ADDR, d);
    check(d, 8'h1b);
    check(ratio, 8'h7c);
    check({6'h00, run, m16}, 8'h03);
    check({6'h00, fuse, rcsel}, 8'h03);
    check({6'h00, s_oe, a_oe}, 8'h03);
    reg_read(OUT_DRIVE_ADDR, d);
    check(d, 8'h04);
    reg_read(SLOW_CTRL_ADDR, d);
    check(d, 8'h00);
    foreach (rows[i])
    begin
      write_read(PLL_CONTROL_ADDR, rows[i][31:24], d);
      check(d, rows[i][23:16]);
      check(ratio, rows[i][15:8]);
      check({6'h00, run, m16}, rows[i][7:0]);
    end
    reg_write(PLL_CONTROL_ADDR, 8'h00);
    req = 1'b1;
    tick(4);
    check({7'h00, run}, 8'h01);
    req = 1'b0;
    tick(4);
    check({7'h00, run}, 8'h00);
    reg_write(9'h1e5, 8'hff);
    reg_read(9'h1e5, d);
    check(d, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      s = 2'(i);
      a = 2'(3 - i);
      reg_write(OUT_DRIVE_ADDR, {4'h0, a, s});
      tick(2);
      check({4'h0, a_drv, s_drv}, {4'h0, a, s});
      check({6'h00, s_oe, a_oe}, {6'h00, s != DRV_HIZ, a != DRV_HIZ});
    end
    rail = 1'b0;
    tick(4);
    repeat (20)
    begin
      check({6'h00, a_out, a_oe}, 8'h00);
      tick(1);
    end
    rail = 1'b1;
    tick(4);
    d = 8'h00;
    repeat (40)
    begin
      tick(1);
      d = d + {7'h00, a_out};
    end
    check({6'h00, d != 8'h00, a_oe}, 8'h03);
    st_en = 1'b0;
    tick(4);
    check({7'h00, s_oe}, 8'h00);
    st_en = 1'b1;
    reg_write(SLOW_CTRL_ADDR, 8'h01);
    tick(4);
    check({7'h00, s_oe}, 8'h00);
    rst = 1'b1;
    tick(8);
    rst = 1'b0;
    tick(1);
    reg_read(SLOW_CTRL_ADDR, d);
    check(d, 8'h01);
    reg_read(PLL_CONTROL_ADDR, d);
    check(d, 8'h1b);
    bk_n = 1'b0;
    tick(4);
    bk_n = 1'b1;
    tick(3);
    reg_read(SLOW_CTRL_ADDR, d);
    check(d, 8'h00);
    check({7'h00, s_oe}, 8'h01);
    watch = 1'b1;
    xon = 1'b1;
    wait_sel(1'b0);
    reg_read(CLK_STATUS_ADDR, d);
    check(d, 8'h02);
    d = 8'h00;
    repeat (40)
    begin
      tick(1);
      d = d + {7'h00, s_out};
    end
    check({7'h00, d != 8'h00}, 8'h01);
    tick(400);
    check({7'h00, rcsel}, 8'h00);
    xon = 1'b0;
    wait_sel(1'b1);
    reg_write(CLK_STATUS_ADDR, 8'hfc);
    reg_read(CLK_STATUS_ADDR, d);
    check(d, 8'h01);
    watch = 1'b0;
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
